// *** malu_pkg.sv ***
// constants and types shared by the address lookup and learning engine
package malu_pkg;

	// table geometry
	localparam int PORTS = 8;
	localparam int PORT_W = 3;
	localparam int MAC_W = 48;
	localparam int TBL_N = 8192;
	localparam int TBL_AW = 13;
	localparam int CAM_N = 128;
	localparam int CAM_AW = 7;
	localparam int MC_BIT = 40;

	// aging: a sweep every half period, so a stale entry is gone within the full period
	localparam longint CLK_HZ = 20_000_000;
	localparam longint AGE_S = 300;
	localparam longint AGE_TICK_CYC = AGE_S * CLK_HZ / 2;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_PEN = 8'h04;
	localparam logic [7:0] OFF_SEC = 8'h08;
	localparam logic [7:0] OFF_STP = 8'h0C;
	localparam logic [7:0] OFF_STLO = 8'h10;
	localparam logic [7:0] OFF_STHI = 8'h14;
	localparam logic [7:0] OFF_STAT = 8'h18;
	localparam logic [7:0] OFF_CNT = 8'h1C;

	// field positions
	localparam int CTRL_HASH = 0;
	localparam int CTRL_AGE = 1;
	localparam int CTRL_STP = 2;
	localparam int STHI_PORT = 16;
	localparam int STHI_GO = 31;

	// reset values
	localparam logic [2:0] CTRL_RST = 3'h3;
	localparam logic [7:0] PEN_RST = 8'hFF;
	localparam logic [7:0] SEC_RST = 8'h00;
	localparam logic [15:0] STP_RST = 16'hFFFF;

	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// frame origin
	localparam logic [1:0] KIND_LOCAL = 2'h0;
	localparam logic [1:0] KIND_RING = 2'h1;
	localparam logic [1:0] KIND_CONV = 2'h2;

	// per-port spanning tree state
	typedef enum logic [1:0] {STP_OFF, STP_BLOCK, STP_LEARN, STP_FWD} malu_stp_t;

	typedef struct packed {
		logic vld;
		logic stat;
		logic fresh;
		logic [PORT_W-1:0] port;
		logic [MAC_W-1:0] mac;
	} malu_entry_t;

endpackage

// *** malu_cam_if.sv ***
// search and write port between the lookup engine and the collision memory
`timescale 1ns/1ns
interface malu_cam_if;
	logic [malu_pkg::MAC_W-1:0] key;
	logic hit;
	logic [malu_pkg::CAM_AW-1:0] hit_idx;
	logic [malu_pkg::PORT_W-1:0] hit_port;
	logic hit_stat;
	logic [malu_pkg::CAM_AW-1:0] free_idx;
	logic full;
	logic wr_en;
	logic [malu_pkg::CAM_AW-1:0] wr_idx;
	malu_pkg::malu_entry_t wr_ent;
	logic age;
	modport eng(output key, wr_en, wr_idx, wr_ent, age,
		input hit, hit_idx, hit_port, hit_stat, free_idx, full);
	modport cam(input key, wr_en, wr_idx, wr_ent, age,
		output hit, hit_idx, hit_port, hit_stat, free_idx, full);
endinterface

// *** malu_cam.sv ***
// 128-entry collision memory with parallel search and aging
`timescale 1ns/1ns
module malu_cam (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// engine side
	malu_cam_if.cam c
);
	typedef struct packed {
		malu_pkg::malu_entry_t [malu_pkg::CAM_N-1:0] e;
	} malu_cam_st_t;

	malu_cam_st_t s;
	malu_cam_st_t next_s;

	////////////////////////////////////////////////////////////////
	// search, free slot, aging and write
	always_comb begin
		next_s = s;
		c.hit = 1'b0;
		c.hit_idx = '0;
		c.hit_port = '0;
		c.hit_stat = 1'b0;
		c.full = 1'b1;
		c.free_idx = '0;
		// lowest matching and lowest free slot win
		for (int i = malu_pkg::CAM_N - 1; i >= 0; i--) begin
			if (s.e[i].vld && s.e[i].mac == c.key) begin
				c.hit = 1'b1;
				c.hit_idx = i[malu_pkg::CAM_AW-1:0];
				c.hit_port = s.e[i].port;
				c.hit_stat = s.e[i].stat;
			end
			if (!s.e[i].vld) begin
				c.full = 1'b0;
				c.free_idx = i[malu_pkg::CAM_AW-1:0];
			end
		end
		// dynamic entries lose freshness, then validity; static ones stay
		if (c.age) begin
			for (int i = 0; i < malu_pkg::CAM_N; i++) begin
				if (s.e[i].vld && !s.e[i].stat) begin
					if (s.e[i].fresh) begin
						next_s.e[i].fresh = 1'b0;
					end else begin
						next_s.e[i].vld = 1'b0;
					end
				end
			end
		end
		// a write in the aging cycle wins, so a refresh is never lost
		if (c.wr_en) begin
			next_s.e[c.wr_idx] = c.wr_ent;
		end
	end

	// every entry empty after reset
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule

// *** malu_top.sv ***
// address lookup, learning, aging and frame filtering engine
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
module malu_top #(
	parameter logic [2:0] CPU_PORT = 3'h7,
	parameter logic [31:0] AGE_TICK = 32'(malu_pkg::AGE_TICK_CYC)
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// axi4-lite register slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// frame summary from the receive macs
	input wire logic frm_valid,
	output logic frm_ready,
	input wire logic [2:0] frm_port,
	input wire logic [47:0] frm_da,
	input wire logic [47:0] frm_sa,
	input wire logic [4:0] frm_err,
	input wire logic frm_buf_full,
	input wire logic frm_bpdu,
	input wire logic [1:0] frm_kind,
	input wire logic frm_own,
	// forwarding decision
	output logic fwd_valid,
	output logic [7:0] fwd_mask,
	output logic [2:0] fwd_src,
	output logic fwd_viol
);
	typedef enum logic [2:0] {S_CLR, S_IDLE, S_DA, S_SA, S_ST, S_AGR, S_AGW} malu_fsm_t;

	typedef struct packed {
		malu_fsm_t state;
		logic [12:0] addr;
		logic [31:0] age_cnt;
		logic age_pend;
		logic [2:0] port;
		logic [47:0] da;
		logic [47:0] sa;
		logic bad;
		logic full;
		logic bpdu;
		logic [1:0] kind;
		logic own;
		logic [7:0] dmask;
		logic [2:0] ctrl;
		logic [7:0] pen;
		logic [7:0] sec;
		logic [15:0] stp;
		logic [31:0] st_lo;
		logic [18:0] st_hi;
		logic st_go;
		logic [15:0] drops;
		logic [15:0] viols;
		logic awready;
		logic wready;
		logic aw_got;
		logic w_got;
		logic [7:0] aw_a;
		logic [31:0] w_d;
		logic [3:0] w_s;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic frm_ready;
		logic fwd_valid;
		logic [7:0] fwd_mask;
		logic [2:0] fwd_src;
		logic fwd_viol;
	} malu_st_t;

	malu_st_t s;
	malu_st_t next_s;
	malu_pkg::malu_entry_t tbl [malu_pkg::TBL_N];
	malu_pkg::malu_entry_t tbl_q;
	logic tw_en;
	logic [12:0] tw_addr;
	malu_pkg::malu_entry_t tw_data;
	malu_cam_if c ();

	malu_cam u_cam (
		.core_clk(core_clk),
		.rst(rst),
		.c(c)
	);

	////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [12:0] tbl_idx(input logic [47:0] m, input logic hash);
		// xor fold in hash mode, low bits in direct mode
		if (hash) begin
			tbl_idx = m[12:0] ^ m[25:13] ^ m[38:26] ^ {4'h0, m[47:39]};
		end else begin
			tbl_idx = m[12:0];
		end
	endfunction

	function automatic logic [7:0] onehot(input logic [2:0] p);
		onehot = 8'h01 << p;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] b);
		merge = o;
		for (int i = 0; i < 4; i++) begin
			if (b[i]) begin
				merge[8*i+:8] = d[8*i+:8];
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		logic [47:0] sa_m;
		logic [47:0] st_mac;
		logic tmatch;
		logic found;
		logic [2:0] fport;
		logic fstat;
		logic pl_en;
		logic pl_stat;
		logic [2:0] pl_port;
		logic viol;
		logic [7:0] mask;
		logic [31:0] wv;
		logic [1:0] pst;
		logic tick;
		sa_m = {s.sa[47:1], 1'b0};
		st_mac = {s.st_hi[15:0], s.st_lo[31:1], 1'b0};
		tmatch = 1'b0;
		found = 1'b0;
		fport = '0;
		fstat = 1'b0;
		pl_en = 1'b0;
		pl_stat = 1'b0;
		pl_port = s.port;
		viol = 1'b0;
		mask = s.dmask;
		wv = '0;
		pst = s.stp[2*s.port+:2];
		tick = s.ctrl[malu_pkg::CTRL_AGE] && s.age_cnt >= AGE_TICK - 32'h1;
		next_s = s;
		next_s.fwd_valid = 1'b0;
		next_s.fwd_viol = 1'b0;
		tw_en = 1'b0;
		tw_addr = s.addr;
		tw_data = '0;
		c.wr_en = 1'b0;
		c.wr_idx = c.free_idx;
		c.wr_ent = '0;
		c.age = 1'b0;
		if (s.state == S_DA) begin
			c.key = s.da;
		end else if (s.state == S_ST) begin
			c.key = st_mac;
		end else begin
			c.key = sa_m;
		end
		// table slot and collision memory are searched together
		tmatch = tbl_q.vld && tbl_q.mac == c.key;
		found = tmatch || c.hit;
		fport = tmatch ? tbl_q.port : c.hit_port;
		fstat = tmatch ? tbl_q.stat : c.hit_stat;

		// axi write: address and data taken in either order
		if (s_axi_awvalid && s.awready) begin
			next_s.aw_got = 1'b1;
			next_s.aw_a = s_axi_awaddr;
		end
		if (s_axi_wvalid && s.wready) begin
			next_s.w_got = 1'b1;
			next_s.w_d = s_axi_wdata;
			next_s.w_s = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		if (s.aw_got && s.w_got && !s.bvalid) begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = malu_pkg::RESP_OKAY;
			unique case (s.aw_a)
				malu_pkg::OFF_CTRL: begin
					wv = merge({29'h0, s.ctrl}, s.w_d, s.w_s);
					next_s.ctrl = wv[2:0];
				end
				malu_pkg::OFF_PEN: begin
					wv = merge({24'h0, s.pen}, s.w_d, s.w_s);
					next_s.pen = wv[7:0];
				end
				malu_pkg::OFF_SEC: begin
					wv = merge({24'h0, s.sec}, s.w_d, s.w_s);
					next_s.sec = wv[7:0];
				end
				malu_pkg::OFF_STP: begin
					wv = merge({16'h0, s.stp}, s.w_d, s.w_s);
					next_s.stp = wv[15:0];
				end
				malu_pkg::OFF_STLO: next_s.st_lo = merge(s.st_lo, s.w_d, s.w_s);
				malu_pkg::OFF_STHI: begin
					wv = merge({13'h0, s.st_hi}, s.w_d, s.w_s);
					next_s.st_hi = wv[18:0];
				end
				malu_pkg::OFF_STAT, malu_pkg::OFF_CNT: ;
				default: next_s.bresp = malu_pkg::RESP_SLVERR;
			endcase
		end

		// axi read
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s.arready) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = malu_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				malu_pkg::OFF_CTRL: next_s.rdata = {29'h0, s.ctrl};
				malu_pkg::OFF_PEN: next_s.rdata = {24'h0, s.pen};
				malu_pkg::OFF_SEC: next_s.rdata = {24'h0, s.sec};
				malu_pkg::OFF_STP: next_s.rdata = {16'h0, s.stp};
				malu_pkg::OFF_STLO: next_s.rdata = s.st_lo;
				malu_pkg::OFF_STHI: next_s.rdata = {s.st_go, 12'h0, s.st_hi};
				malu_pkg::OFF_STAT: next_s.rdata = {29'h0, c.full, s.st_go,
					s.state != S_IDLE};
				malu_pkg::OFF_CNT: next_s.rdata = {s.viols, s.drops};
				default: begin
					next_s.rdata = '0;
					next_s.rresp = malu_pkg::RESP_SLVERR;
				end
			endcase
		end

		// aging period counter, halted while aging is off
		if (s.ctrl[malu_pkg::CTRL_AGE]) begin
			if (tick) begin
				next_s.age_cnt = '0;
				next_s.age_pend = 1'b1;
			end else begin
				next_s.age_cnt = s.age_cnt + 32'h1;
			end
		end

		// placement of a learned or static address
		unique case (s.state)
			S_SA: begin
				// a known address on another port is a violation only on a secured port
				viol = found && fport != s.port && s.sec[s.port];
				pl_en = !s.bad && !viol && pst != malu_pkg::STP_OFF && pst != malu_pkg::STP_BLOCK;
				if (s.kind == malu_pkg::KIND_CONV && s.own) begin
					pl_en = 1'b0;
				end
				if (s.bad || s.full) begin
					pl_en = 1'b0;
				end
			end
			S_ST: begin
				pl_en = 1'b1;
				pl_stat = 1'b1;
				pl_port = s.st_hi[malu_pkg::STHI_PORT+:3];
			end
			default: ;
		endcase
		if (pl_en) begin
			if (tmatch) begin
				// static entries are kept unless a static write replaces them
				if (!tbl_q.stat || pl_stat) begin
					tw_en = 1'b1;
				end
			end else if (c.hit) begin
				if (!c.hit_stat || pl_stat) begin
					c.wr_en = 1'b1;
					c.wr_idx = c.hit_idx;
				end
			end else if (!tbl_q.vld) begin
				tw_en = 1'b1;
			end else if (!c.full) begin
				c.wr_en = 1'b1;
			end
			// full collision memory: the address is just not learned
			tw_data = {1'b1, pl_stat, 1'b1, pl_port, c.key};
			c.wr_ent = tw_data;
		end

		// engine sequencer
		unique case (s.state)
			S_CLR: begin
				// wipe one slot per cycle, the table is unusable until done
				tw_en = 1'b1;
				tw_data = '0;
				next_s.addr = s.addr + 13'h1;
				if (s.addr == 13'h1FFF) begin
					next_s.state = S_IDLE;
				end
			end
			S_IDLE: begin
				if (frm_valid && s.frm_ready) begin
					next_s.port = frm_port;
					next_s.da = frm_da;
					next_s.sa = frm_sa;
					next_s.bad = |frm_err;
					next_s.full = frm_buf_full;
					next_s.bpdu = frm_bpdu;
					next_s.kind = frm_kind;
					next_s.own = frm_own;
					next_s.addr = tbl_idx(frm_da, s.ctrl[malu_pkg::CTRL_HASH]);
					next_s.state = S_DA;
				end else if (s.age_pend) begin
					c.age = 1'b1;
					// a tick landing in this very cycle is kept, not lost
					next_s.age_pend = tick;
					next_s.addr = '0;
					next_s.state = S_AGR;
				end else if (s.st_go) begin
					next_s.addr = tbl_idx(st_mac, s.ctrl[malu_pkg::CTRL_HASH]);
					next_s.state = S_ST;
				end
			end
			S_DA: begin
				// unicast hit goes to one port, or is dropped if that is the receiving port; anything else floods
				if (s.da[malu_pkg::MC_BIT] || !found) begin
					mask = s.pen & ~onehot(s.port);
				end else if (fport == s.port) begin
					mask = 8'h00;
				end else begin
					mask = onehot(fport) & s.pen;
				end
				if (s.bad || s.full || s.kind == malu_pkg::KIND_CONV) begin
					mask = 8'h00;
				end
				if (s.ctrl[malu_pkg::CTRL_STP]) begin
					if (pst != malu_pkg::STP_FWD) begin
						mask = (s.bpdu && pst != malu_pkg::STP_OFF) ? onehot(CPU_PORT) : 8'h00;
					end else if (s.bpdu) begin
						mask = onehot(CPU_PORT);
					end
				end
				next_s.dmask = mask;
				next_s.addr = tbl_idx(sa_m, s.ctrl[malu_pkg::CTRL_HASH]);
				next_s.state = S_SA;
			end
			S_SA: begin
				next_s.fwd_valid = 1'b1;
				next_s.fwd_src = s.port;
				next_s.fwd_viol = viol;
				next_s.fwd_mask = viol ? 8'h00 : s.dmask;
				if (viol || s.dmask == 8'h00) begin
					next_s.drops = s.drops + 16'h1;
				end
				if (viol) begin
					next_s.viols = s.viols + 16'h1;
				end
				next_s.state = S_IDLE;
			end
			S_ST: begin
				next_s.st_go = 1'b0;
				next_s.state = S_IDLE;
			end
			S_AGR: next_s.state = S_AGW;
			S_AGW: begin
				// second miss of a sweep removes a dynamic entry
				if (tbl_q.vld && !tbl_q.stat) begin
					tw_en = 1'b1;
					tw_data = tbl_q;
					if (tbl_q.fresh) begin
						tw_data.fresh = 1'b0;
					end else begin
						tw_data.vld = 1'b0;
					end
				end
				next_s.addr = s.addr + 13'h1;
				next_s.state = (s.addr == 13'h1FFF) ? S_IDLE : S_AGR;
			end
			default: next_s.state = S_CLR;
		endcase

		// go set by software wins over its clear
		if (s.aw_got && s.w_got && !s.bvalid && s.aw_a == malu_pkg::OFF_STHI &&
			s.w_s[3] && s.w_d[malu_pkg::STHI_GO]) begin
			next_s.st_go = 1'b1;
		end
		next_s.awready = !next_s.aw_got && !next_s.bvalid;
		next_s.wready = !next_s.w_got && !next_s.bvalid;
		next_s.arready = !next_s.rvalid;
		next_s.frm_ready = next_s.state == S_IDLE && !next_s.age_pend && !next_s.st_go;
	end

	////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.state <= S_CLR;
			s.ctrl <= malu_pkg::CTRL_RST;
			s.pen <= malu_pkg::PEN_RST;
			s.sec <= malu_pkg::SEC_RST;
			s.stp <= malu_pkg::STP_RST;
		end else begin
			s <= next_s;
		end
	end

	// table ram: write port from the sequencer, read follows the next address
	always_ff @(posedge core_clk) begin
		if (tw_en) begin
			tbl[tw_addr] <= tw_data;
		end
		tbl_q <= tbl[next_s.addr];
	end

	////////////////////////////////////////////////////////////////
	// outputs
	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rresp = s.rresp;
	assign s_axi_rdata = s.rdata;
	assign frm_ready = s.frm_ready;
	assign fwd_valid = s.fwd_valid;
	assign fwd_mask = s.fwd_mask;
	assign fwd_src = s.fwd_src;
	assign fwd_viol = s.fwd_viol;
endmodule

// *** malu_top_chk.sv ***
// concurrent checks on the frame decision path of the lookup engine
`timescale 1ns/1ns
module malu_top_chk (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// frame summary
	input wire logic frm_valid,
	input wire logic frm_ready,
	input wire logic [2:0] frm_port,
	input wire logic [4:0] frm_err,
	input wire logic frm_buf_full,
	input wire logic [1:0] frm_kind,
	// decision
	input wire logic fwd_valid,
	input wire logic [7:0] fwd_mask,
	input wire logic [2:0] fwd_src,
	input wire logic fwd_viol
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	// a taken summary, and the decision pulse three edges later
	sequence s_take;
		frm_valid && frm_ready;
	endsequence
	sequence s_decide;
		##3 fwd_valid;
	endsequence
	////////////////////////////////////////////////////////////////
	a_decision_latency: assert property (s_take |-> s_decide)
		else $error("decision missing three cycles after a taken frame");
	a_err_no_fwd: assert property (s_take ##0 (frm_err != 5'h00) |-> ##3 fwd_mask == 8'h00)
		else $error("errored frame was forwarded");
	a_full_no_fwd: assert property (s_take ##0 frm_buf_full |-> ##3 fwd_mask == 8'h00)
		else $error("frame with full input buffer was forwarded");
	a_src_echo: assert property (s_take |-> ##3 fwd_src == $past(frm_port, 3))
		else $error("decision names the wrong receiving port");
	a_no_self: assert property (fwd_valid |-> !fwd_mask[fwd_src])
		else $error("frame sent back to its own port");
	a_conv_no_fwd: assert property (s_take ##0 (frm_kind == malu_pkg::KIND_CONV) |-> ##3 fwd_mask == 8'h00)
		else $error("convergence message was forwarded");
	a_viol_drop: assert property (fwd_valid && fwd_viol |-> fwd_mask == 8'h00)
		else $error("violating frame was forwarded");
	a_busy_between: assert property (s_take |=> !frm_ready [*2])
		else $error("new frame accepted during lookup");
	a_fwd_pulse: assert property (fwd_valid |=> !fwd_valid)
		else $error("decision pulse longer than one cycle");
	// the table clear after reset keeps the engine closed
	a_clear_hold: assert property ($fell(rst) |-> !frm_ready [*8])
		else $error("frames accepted before table clear");
endmodule

bind malu_top malu_top_chk malu_top_chk_inst (.core_clk, .rst, .frm_valid, .frm_ready, .frm_port,
	.frm_err, .frm_buf_full, .frm_kind, .fwd_valid, .fwd_mask, .fwd_src, .fwd_viol);

// *** malu_mac_src.sv ***
// model of the receive mac side offering frame summaries to the engine
`timescale 1ns/1ns
module malu_mac_src (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// bench requests
	input wire logic req,
	input wire logic [108:0] req_frm,
	input wire logic [3:0] req_dly,
	// engine side
	output logic frm_valid,
	output logic [108:0] frm_bus,
	input wire logic frm_ready
);
	logic pend;
	logic [3:0] cnt;
	logic [108:0] held;
	////////////////////////////////////////////////////////////////
	// offer after a delay and hold until taken; idle lines toggle so stale data never passes
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			frm_valid <= 1'b0;
			frm_bus <= '0;
			pend <= 1'b0;
			cnt <= 4'h0;
			held <= '0;
		end else if (frm_valid) begin
			if (frm_ready) begin
				frm_valid <= 1'b0;
				frm_bus <= ~held;
			end
		end else if (req) begin
			pend <= 1'b1;
			held <= req_frm;
			cnt <= req_dly;
			frm_bus <= ~frm_bus;
		end else if (pend && cnt == 4'h0) begin
			frm_valid <= 1'b1;
			frm_bus <= held;
			pend <= 1'b0;
		end else begin
			cnt <= cnt - 4'h1;
			frm_bus <= ~frm_bus;
		end
	end
endmodule

// *** malu_bench.sv ***
// self-checking bench for the address lookup and learning engine
`timescale 1ns/1ns
module malu_bench;
	localparam logic [2:0] CPU = 3'h7;
	localparam logic [47:0] BC = 48'hFFFFFFFFFFFF;
	logic core_clk = 1'b0, rst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, pen = 8'hFF, fwd_mask;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, lf = 32'h4165F8E2;
	logic [3:0] s_axi_wstrb = 4'hF, req_dly = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, req = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic frm_valid, frm_ready, fwd_valid, fwd_viol;
	logic [2:0] fwd_src;
	logic [108:0] frm_bus, req_frm = '0;
	logic [47:0] x, y, z, w, a, b, c, e;
	logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h40};
	logic [31:0] rx [5] = '{32'h3, 32'hFF, 32'h0, 32'hFFFF, 32'h0};
	int fail_count = 0, cmp_count = 0, cyc = 0;

	// tick must exceed one 16384-cycle sweep, or sweeps run back to back and frames starve
	malu_top #(.CPU_PORT(CPU), .AGE_TICK(32'h00004650)) malu_top_inst (.core_clk, .rst,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .frm_valid,
		.frm_ready, .frm_port(frm_bus[108:106]), .frm_da(frm_bus[105:58]), .frm_sa(frm_bus[57:10]),
		.frm_err(frm_bus[9:5]), .frm_buf_full(frm_bus[4]), .frm_bpdu(frm_bus[3]),
		.frm_kind(frm_bus[2:1]), .frm_own(frm_bus[0]), .fwd_valid, .fwd_mask, .fwd_src, .fwd_viol);
	malu_mac_src malu_mac_src_inst (.core_clk, .rst, .req, .req_frm, .req_dly, .frm_valid,
		.frm_bus, .frm_ready);
	////////////////////////////////////////////////////////////////
	// clock and hang guard; ceiling covers clear, one sweep and the aging wait
	always #25 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 95000) begin
			fail_count++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////
	// expectations and random addresses
	function automatic logic [7:0] fl(input logic [2:0] p);
		return pen & ~(8'h01 << p);
	endfunction
	function automatic logic [47:0] umac();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return {lf[15:9], 1'b0, lf[7:0], lf[31:1], 1'b0};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// register bus master: each valid released once its ready is seen
	task automatic wr(input logic [7:0] ad, input logic [31:0] dt, output logic [1:0] rs);
		@(posedge core_clk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= dt;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (s_axi_bvalid !== 1'b1) begin
			@(posedge core_clk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
		@(posedge core_clk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (s_axi_rvalid !== 1'b1) begin
			@(posedge core_clk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end
		dt = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// one frame through the model; flags are err, full, bpdu, kind, own
	task automatic fr(input logic [2:0] p, input logic [47:0] da, input logic [47:0] sa,
			input logic [9:0] ef, input logic [7:0] em, input logic ev);
		@(posedge core_clk);
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		req <= 1'b1;
		req_frm <= {p, da, sa, ef};
		req_dly <= {2'h0, lf[1:0]};
		@(posedge core_clk);
		req <= 1'b0;
		while (fwd_valid !== 1'b1) @(negedge core_clk);
		check({24'h0, fwd_mask}, {24'h0, em});
		check({28'h0, fwd_src, fwd_viol}, {28'h0, p, ev});
	endtask
	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			rd(ra[i], d, r);
			check(d, rx[i]);
			check({30'h0, r}, {30'h0, i == 4 ? malu_pkg::RESP_SLVERR : malu_pkg::RESP_OKAY});
		end
		wr(8'h40, 32'hFFFFFFFF, r);
		check({30'h0, r}, {30'h0, malu_pkg::RESP_SLVERR});
		wr(malu_pkg::OFF_CTRL, 32'h1, r);
		x = umac();
		y = umac();
		z = umac();
		w = umac();
		c = umac();
		// miss floods, hit forwards, own port drops, an address moves
		fr(3'h0, y, x, 10'h000, fl(3'h0), 1'b0);
		fr(3'h1, x, y, 10'h000, 8'h01, 1'b0);
		fr(3'h0, x, y, 10'h000, 8'h00, 1'b0);
		fr(3'h2, y, w, 10'h000, 8'h01, 1'b0);
		fr(3'h1, x | 48'h010000000000, z, 10'h000, fl(3'h1), 1'b0);
		fr(3'h2, BC, z | 48'h1, 10'h000, fl(3'h2), 1'b0);
		fr(3'h3, z, w, 10'h000, 8'h04, 1'b0);
		// every error kind and a full buffer: dropped and not learned
		for (int i = 0; i < 6; i++) begin
			e = umac();
			fr(3'h3, x, e, 10'h010 << i, 8'h00, 1'b0);
			fr(3'h3, e, w, 10'h000, fl(3'h3), 1'b0);
		end
		// secured port flags, open port moves
		wr(malu_pkg::OFF_SEC, 32'h10, r);
		fr(3'h4, w, x, 10'h000, 8'h00, 1'b1);
		fr(3'h3, x, w, 10'h000, 8'h01, 1'b0);
		fr(3'h5, w, x, 10'h000, 8'h08, 1'b0);
		fr(3'h3, x, w, 10'h000, 8'h20, 1'b0);
		rd(malu_pkg::OFF_CNT, d, r);
		check(d >> 16, 32'h1);
		wr(malu_pkg::OFF_PEN, 32'hDF, r);
		pen = 8'hDF;
		fr(3'h3, x, w, 10'h000, 8'h00, 1'b0);
		fr(3'h3, BC, w, 10'h000, fl(3'h3), 1'b0);
		wr(malu_pkg::OFF_PEN, 32'hFF, r);
		pen = 8'hFF;
		// static entry stays put
		wr(malu_pkg::OFF_STLO, z[31:0], r);
		wr(malu_pkg::OFF_STHI, {1'b1, 12'h0, 3'h6, z[47:32]}, r);
		fr(3'h2, y, z, 10'h000, 8'h01, 1'b0);
		fr(3'h1, z, y, 10'h000, 8'h40, 1'b0);
		// colliding sources in direct then hashed mode
		for (int m = 0; m < 2; m++) begin
			wr(malu_pkg::OFF_CTRL, 32'(m), r);
			a = umac();
			b = a ^ (m == 1 ? 48'h000004002000 : 48'h000000100000);
			fr(3'h2, BC, a, 10'h000, fl(3'h2), 1'b0);
			fr(3'h4, BC, b, 10'h000, fl(3'h4), 1'b0);
			fr(3'h1, b, y, 10'h000, 8'h10, 1'b0);
			fr(3'h1, a, y, 10'h000, 8'h04, 1'b0);
		end
		// spanning tree states on port 3
		wr(malu_pkg::OFF_CTRL, 32'h5, r);
		for (int s = 1; s < 4; s++) begin
			wr(malu_pkg::OFF_STP, 32'hFFFF ^ (32'(s ^ 3) << 6), r);
			fr(3'h3, BC, w, 10'h008, 8'h01 << CPU, 1'b0);
			fr(3'h3, BC, w, 10'h000, s == 3 ? fl(3'h3) : 8'h00, 1'b0);
		end
		// convergence learns without forwarding, own ones are ignored, ring learns
		fr(3'h2, BC, c, 10'h004, 8'h00, 1'b0);
		fr(3'h1, c, y, 10'h000, 8'h04, 1'b0);
		e = umac();
		fr(3'h2, BC, e, 10'h005, 8'h00, 1'b0);
		fr(3'h1, e, y, 10'h000, fl(3'h1), 1'b0);
		e = umac();
		fr(3'h6, BC, e, 10'h002, fl(3'h6), 1'b0);
		fr(3'h1, e, y, 10'h000, 8'h40, 1'b0);
		// aging removes the dynamic entry only
		wr(malu_pkg::OFF_CTRL, 32'h3, r);
		repeat (40000) @(posedge core_clk);
		fr(3'h1, c, y, 10'h000, fl(3'h1), 1'b0);
		fr(3'h1, z, y, 10'h000, 8'h40, 1'b0);
		end_of_test();
	end
endmodule
